// ===== hw/frame_words.sv
// Purpose: Serial control word capture and status word output, one frame of 32 slots.
// Assumes: BIT_STB pulses once per serial bit, two or more clocks apart.
// Notes:   FRAME_PULSE_IN arms the first bit of each frame.
`timescale 1ns/1ps
module frame_words
    import framer_words_pkg::*;
(
    // Clock and reset
    input  wire logic                         CLK,
    input  wire logic                         RST_N,
    // Serial streams
    input  wire logic                         BIT_STB,
    input  wire logic                         FRAME_PULSE_IN,
    input  wire logic                         CONTROL_STREAM_0,
    input  wire logic                         CONTROL_STREAM_1,
    output logic                              STATUS_STREAM_OUT,
    // Status from the framer core
    input  wire logic                         FRAME_SYNC_LOST,
    input  wire logic                         MULTIFRAME_SYNC_LOST,
    input  wire logic                         ALIGN_ERROR,
    input  wire logic                         SLIP_EVENT,
    input  wire logic                         RECEIVE_ALL_ONES_ALARM,
    input  wire logic                         SLOT16_ALL_ONES_ALARM,
    input  wire logic                         EXTERNAL_STATUS_LEVEL,
    input  wire logic                         REMOTE_SUBMF2_OK,
    input  wire logic                         REMOTE_SUBMF1_OK,
    input  wire logic                         CRC_TIMER,
    input  wire logic                         CRC_REFRAME_FORCED,
    input  wire logic                         CRC_FRAME_MISSING,
    input  wire logic                         PHASE_BIT8,
    input  wire logic [4:0]                   TX_TIMESLOT_COUNT,
    input  wire logic [2:0]                   TX_BIT_COUNT,
    input  wire logic [7:0]                   CRC_ERROR_TALLY,
    input  wire logic [7:0]                   RX_FRAME_ALIGN,
    input  wire logic [7:0]                   RX_MULTIFRAME_ALIGN,
    input  wire logic [7:0]                   RX_NONALIGN_WORD,
    // Received signalling write port
    input  wire logic                         RX_CAS_WE,
    input  wire logic [3:0]                   RX_CAS_SLOT,
    input  wire logic [7:0]                   RX_CAS_DATA,
    // Per-channel lookup
    input  wire logic [4:0]                   LOOKUP_CH,
    output logic                              ALTERNATE_DIGIT_INVERSION,
    output logic                              CHAN_LOOPBACK,
    output logic [3:0]                        TX_SIG_ABCD,
    // Transmit overhead words
    output logic [7:0]                        TX_FRAME_ALIGN,
    output logic [7:0]                        TX_MULTIFRAME_ALIGN,
    output logic [7:0]                        TX_NONALIGN_WORD
);
    // ************************************************************
    // Frame position and deserialisers
    // ************************************************************
    logic [7:0] pos_reg, pos_next;
    logic       first_reg, first_next;
    logic [6:0] sh0_reg, sh0_next;
    logic [6:0] sh1_reg, sh1_next;
    logic [7:0] out_sh_reg, out_sh_next;
    logic       slip_tgl_reg, slip_tgl_next;
    logic [7:0] fas_reg, fas_next;
    logic [7:0] mfas_reg, mfas_next;
    logic [7:0] nfas_reg, nfas_next;
    logic       sel_low_reg, sel_low_next;

    logic [4:0] cur_ch;
    logic [4:0] next_ch;
    logic       word_done;
    logic [7:0] word0;
    logic [7:0] word1;
    logic       pcc_we;
    logic       sig_we;
    logic [7:0] pcc_rdata;
    logic [7:0] tsig_rdata;
    logic [7:0] rcas_rdata;
    logic [3:0] tsig_raddr;
    logic [7:0] status_word;

    assign cur_ch    = pos_reg[7:3];
    assign next_ch   = 5'(cur_ch + 5'h01);
    assign word_done = BIT_STB && !FRAME_PULSE_IN && !first_reg && (pos_reg[2:0] == LAST_BIT);
    assign word0     = {sh0_reg, CONTROL_STREAM_0};
    assign word1     = {sh1_reg, CONTROL_STREAM_1};
    assign pcc_we    = word_done && (cur_ch != CH_NO_PCC_A) && (cur_ch != CH_NO_PCC_B);
    assign sig_we    = word_done && (cur_ch != CH_TX_MFAS) && (cur_ch <= CH_SIG_LAST);

    // Builds the status word for one slot of the outgoing frame
    function automatic logic [7:0] status_for(input logic [4:0] ch, input logic [7:0] cas);
        logic [7:0] w;
        w = STATUS_FILL;
        unique case (ch)
            CH_RX_MFAS:   w = RX_MULTIFRAME_ALIGN;
            CH_RX_FAS:    w = RX_FRAME_ALIGN;
            CH_RX_NFAS:   w = RX_NONALIGN_WORD;
            CH_SYNC_STAT: w = {FRAME_SYNC_LOST, MULTIFRAME_SYNC_LOST, ALIGN_ERROR, slip_tgl_reg,
                               RECEIVE_ALL_ONES_ALARM, SLOT16_ALL_ONES_ALARM,
                               EXTERNAL_STATUS_LEVEL, 1'b0};
            CH_PHASE:     w = {TX_TIMESLOT_COUNT, TX_BIT_COUNT};
            CH_CRC_COUNT: w = CRC_ERROR_TALLY;
            CH_CRC_STAT:  w = {REMOTE_SUBMF2_OK, REMOTE_SUBMF1_OK, 1'b0, CRC_TIMER,
                               CRC_REFRAME_FORCED, CRC_FRAME_MISSING, 1'b0, PHASE_BIT8};
            default: begin
                if (ch <= CH_SIG_LAST) begin
                    w = cas;
                end
            end
        endcase
        return w;
    endfunction

    always_comb begin
        status_word = status_for(next_ch, rcas_rdata);
    end

    always_comb begin
        pos_next      = pos_reg;
        first_next    = first_reg;
        sh0_next      = sh0_reg;
        sh1_next      = sh1_reg;
        out_sh_next   = out_sh_reg;
        slip_tgl_next = slip_tgl_reg ^ SLIP_EVENT;
        fas_next      = fas_reg;
        mfas_next     = mfas_reg;
        nfas_next     = nfas_reg;
        if (FRAME_PULSE_IN) begin
            pos_next   = POS_IDLE;
            first_next = 1'b1;
        end else if (BIT_STB) begin
            pos_next   = 8'(pos_reg + 8'h01);
            first_next = 1'b0;
            sh0_next   = word0[6:0];
            sh1_next   = word1[6:0];
            if (pos_reg[2:0] == LAST_BIT) begin
                out_sh_next = status_word;
            end else begin
                out_sh_next = {out_sh_reg[6:0], 1'b0};
            end
            if (word_done) begin
                unique case (cur_ch)
                    CH_TX_MFAS: mfas_next = word1;
                    CH_TX_FAS:  fas_next  = word1;
                    CH_TX_NFAS: nfas_next = word1;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pos_reg      <= POS_IDLE;
            first_reg    <= 1'b1;
            sh0_reg      <= '0;
            sh1_reg      <= '0;
            out_sh_reg   <= STATUS_FILL;
            slip_tgl_reg <= 1'b0;
            fas_reg      <= WORD_RESET;
            mfas_reg     <= WORD_RESET;
            nfas_reg     <= WORD_RESET;
        end else begin
            pos_reg      <= pos_next;
            first_reg    <= first_next;
            sh0_reg      <= sh0_next;
            sh1_reg      <= sh1_next;
            out_sh_reg   <= out_sh_next;
            slip_tgl_reg <= slip_tgl_next;
            fas_reg      <= fas_next;
            mfas_reg     <= mfas_next;
            nfas_reg     <= nfas_next;
        end
    end

    assign STATUS_STREAM_OUT   = out_sh_reg[7];
    assign TX_FRAME_ALIGN      = fas_reg;
    assign TX_MULTIFRAME_ALIGN = mfas_reg;
    assign TX_NONALIGN_WORD    = nfas_reg;

    // ************************************************************
    // Word memories
    // ************************************************************
    word_store #(.WIDTH(8), .DEPTH(CHANNELS), .AW(CH_BITS)) pcc_store (
        .CLK   (CLK),
        .RST_N (RST_N),
        .WE    (pcc_we),
        .WADDR (cur_ch),
        .WDATA (word0),
        .RADDR (LOOKUP_CH),
        .RDATA (pcc_rdata)
    );

    // Channels 16..30 fetch the lower nibble of slot N-15
    assign tsig_raddr = (LOOKUP_CH > SIG_UPPER) ? 4'(LOOKUP_CH - SIG_UPPER) : LOOKUP_CH[3:0];

    word_store #(.WIDTH(8), .DEPTH(16), .AW(4)) tx_sig_store (
        .CLK   (CLK),
        .RST_N (RST_N),
        .WE    (sig_we),
        .WADDR (cur_ch[3:0]),
        .WDATA (word1),
        .RADDR (tsig_raddr),
        .RDATA (tsig_rdata)
    );

    word_store #(.WIDTH(8), .DEPTH(16), .AW(4)) rx_cas_store (
        .CLK   (CLK),
        .RST_N (RST_N),
        .WE    (RX_CAS_WE),
        .WADDR (RX_CAS_SLOT),
        .WDATA (RX_CAS_DATA),
        .RADDR (next_ch[3:0]),
        .RDATA (rcas_rdata)
    );

    // ************************************************************
    // Per-channel lookup outputs
    // ************************************************************
    always_comb begin
        sel_low_next = LOOKUP_CH > SIG_UPPER;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sel_low_reg <= 1'b0;
        end else begin
            sel_low_reg <= sel_low_next;
        end
    end

    assign ALTERNATE_DIGIT_INVERSION = !pcc_rdata[PCC_ADI_BIT];
    assign CHAN_LOOPBACK             = pcc_rdata[PCC_LOOP_BIT];
    assign TX_SIG_ABCD               = sel_low_reg ? tsig_rdata[3:0] : tsig_rdata[7:4];
endmodule // frame_words

// ===== hw/framer_words_pkg.sv
// Purpose: Shared constants for the frame control and status word block.
// Assumes: 32 channels of 8 bits per frame, sent most significant bit first.
// Notes:   Channel numbers below are slots within one frame.
package framer_words_pkg;

    localparam int unsigned CHANNELS     = 32;
    localparam int unsigned CH_BITS      = 5;
    localparam int unsigned POS_BITS     = 8;

    // Frame position held while waiting for the first bit of a frame
    localparam logic [7:0]  POS_IDLE     = 8'hFF;
    localparam logic [2:0]  LAST_BIT     = 3'h7;

    // Control stream slots
    localparam logic [4:0]  CH_TX_MFAS   = 5'h00;
    localparam logic [4:0]  CH_SIG_LAST  = 5'h0F;
    localparam logic [4:0]  CH_TX_FAS    = 5'h10;
    localparam logic [4:0]  CH_TX_NFAS   = 5'h11;
    localparam logic [4:0]  CH_NO_PCC_A  = 5'h0F;
    localparam logic [4:0]  CH_NO_PCC_B  = 5'h1F;
    localparam logic [4:0]  SIG_UPPER    = 5'h0F;

    // Status stream slots
    localparam logic [4:0]  CH_RX_MFAS   = 5'h00;
    localparam logic [4:0]  CH_RX_FAS    = 5'h10;
    localparam logic [4:0]  CH_RX_NFAS   = 5'h11;
    localparam logic [4:0]  CH_SYNC_STAT = 5'h12;
    localparam logic [4:0]  CH_PHASE     = 5'h13;
    localparam logic [4:0]  CH_CRC_COUNT = 5'h14;
    localparam logic [4:0]  CH_CRC_STAT  = 5'h15;

    // Per-channel control word fields
    localparam int unsigned PCC_ADI_BIT  = 7;
    localparam int unsigned PCC_LOOP_BIT = 6;

    // Values after reset and for empty slots
    localparam logic [7:0]  WORD_RESET   = 8'h00;
    localparam logic [7:0]  STATUS_FILL  = 8'h00;

endpackage

// ===== hw/word_store.sv
// Purpose: Small word memory, one write port and one registered read port.
// Assumes: Read data appear one clock after the read address.
// Notes:   Contents are not reset; the read register is.
`timescale 1ns/1ps
module word_store #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32,
    parameter int unsigned AW    = 5
) (
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             RST_N,
    // Write port
    input  wire logic             WE,
    input  wire logic [AW-1:0]    WADDR,
    input  wire logic [WIDTH-1:0] WDATA,
    // Read port
    input  wire logic [AW-1:0]    RADDR,
    output logic      [WIDTH-1:0] RDATA
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rdata_next;

    always_comb begin
        rdata_next = mem[RADDR];
    end

    always_ff @(posedge CLK) begin
        if (WE) begin
            mem[WADDR] <= WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= '0;
        end else begin
            RDATA <= rdata_next;
        end
    end
endmodule // word_store

// ===== tb/frame_host.sv
// Purpose: Controller model driving both control streams, reading the status stream.
// Assumes: Drives on the falling edge, four clocks per serial bit.
// Notes:   Word arrays are read and set by the bench.
`timescale 1ns/1ps
module frame_host (
    // Clock
    input  wire logic CLK,
    // Serial streams
    input  wire logic STATUS_STREAM_OUT,
    output logic      BIT_STB,
    output logic      FRAME_PULSE_IN,
    output logic      CONTROL_STREAM_0,
    output logic      CONTROL_STREAM_1
);
    logic [7:0] ctl0 [32];
    logic [7:0] ctl1 [32];
    logic [7:0] stat [32];
    initial begin
        BIT_STB = 1'b0;
        FRAME_PULSE_IN = 1'b0;
        CONTROL_STREAM_0 = 1'b0;
        CONTROL_STREAM_1 = 1'b0;
        for (int n = 0; n < 32; n++) begin
            ctl0[n] = {n[1:0], 6'h2A};
            ctl1[n] = {n[3:0], ~n[3:0]};
        end
        ctl1[0] = 8'h0B;
        ctl1[16] = 8'h9B;
        ctl1[17] = 8'hDF;
    end
    task automatic frame();
        @(negedge CLK) FRAME_PULSE_IN = 1'b1;
        @(negedge CLK) FRAME_PULSE_IN = 1'b0;
        @(negedge CLK);
        for (int k = 0; k < 256; k++) begin
            @(negedge CLK) BIT_STB = 1'b1;
            @(negedge CLK) BIT_STB = 1'b0;
            CONTROL_STREAM_0 = ctl0[k/8][7-k%8];
            CONTROL_STREAM_1 = ctl1[k/8][7-k%8];
            @(negedge CLK) stat[k/8][7-k%8] = STATUS_STREAM_OUT;
            @(negedge CLK);
        end
        // Lines left between frames carry no stale data
        CONTROL_STREAM_0 = ~CONTROL_STREAM_0;
        CONTROL_STREAM_1 = ~CONTROL_STREAM_1;
    endtask
endmodule // frame_host

// ===== tb/frame_words_bench.sv
// Purpose: Self-checking bench for frame_words.
// Assumes: The host model runs whole frames; inputs change between frames.
// Notes:   Two frames with different inputs and control words.
`timescale 1ns/1ps
module frame_words_bench;
    import framer_words_pkg::*;
    logic       CLK = 1'b0;
    logic       RST_N = 1'b0;
    logic       stb, fp, cs0, cs1, sso, alternate_digit_inversion, lpb;
    logic       slip = 1'b0;
    logic       cas_we = 1'b0;
    logic [3:0] cas_slot = 4'h0;
    logic [4:0] lch = 5'h00;
    logic [5:0] sa = 6'h00;
    logic [5:0] sb = 6'h00;
    logic [7:0] tph = 8'h00, tally = 8'h00, rfa = 8'h00, rmf = 8'h00, rnf = 8'h00;
    logic [7:0] cas_d = 8'h00, tfa, tmf, tnf, v, e;
    logic [3:0] abcd;
    int         n_mismatch = 0;
    int         check_count = 0;
    always #5 CLK = ~CLK;
    frame_host u_host (.CLK(CLK), .STATUS_STREAM_OUT(sso), .BIT_STB(stb),
        .FRAME_PULSE_IN(fp), .CONTROL_STREAM_0(cs0), .CONTROL_STREAM_1(cs1));
    frame_words u_dut (.CLK(CLK), .RST_N(RST_N), .BIT_STB(stb), .FRAME_PULSE_IN(fp),
        .CONTROL_STREAM_0(cs0), .CONTROL_STREAM_1(cs1), .STATUS_STREAM_OUT(sso),
        .FRAME_SYNC_LOST(sa[5]), .MULTIFRAME_SYNC_LOST(sa[4]), .ALIGN_ERROR(sa[3]),
        .SLIP_EVENT(slip), .RECEIVE_ALL_ONES_ALARM(sa[2]), .SLOT16_ALL_ONES_ALARM(sa[1]),
        .EXTERNAL_STATUS_LEVEL(sa[0]), .REMOTE_SUBMF2_OK(sb[5]), .REMOTE_SUBMF1_OK(sb[4]),
        .CRC_TIMER(sb[3]), .CRC_REFRAME_FORCED(sb[2]), .CRC_FRAME_MISSING(sb[1]),
        .PHASE_BIT8(sb[0]), .TX_TIMESLOT_COUNT(tph[7:3]), .TX_BIT_COUNT(tph[2:0]),
        .CRC_ERROR_TALLY(tally), .RX_FRAME_ALIGN(rfa), .RX_MULTIFRAME_ALIGN(rmf),
        .RX_NONALIGN_WORD(rnf), .RX_CAS_WE(cas_we), .RX_CAS_SLOT(cas_slot),
        .RX_CAS_DATA(cas_d), .LOOKUP_CH(lch), .ALTERNATE_DIGIT_INVERSION(alternate_digit_inversion),
        .CHAN_LOOPBACK(lpb), .TX_SIG_ABCD(abcd), .TX_FRAME_ALIGN(tfa),
        .TX_MULTIFRAME_ALIGN(tmf), .TX_NONALIGN_WORD(tnf));
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge CLK);
        check("reset status", {7'h00, sso}, 8'h00);
        check("reset tx words", tfa | tmf | tnf, 8'h00);
        check("reset lookup", {2'h0, alternate_digit_inversion, lpb, abcd}, 8'h20);
        @(negedge CLK) RST_N = 1'b1;
        for (int i = 0; i < 2; i++) begin
            v = i ? 8'hA5 : 8'h5A;
            {sa, sb, tph, tally} = {v[5:0], ~v[5:0], v, v + 8'h11};
            {rfa, rmf, rnf} = {~v, v ^ 8'h3C, v ^ 8'hC3};
            for (int n = 1; n < 16; n++) begin
                @(negedge CLK) cas_we = 1'b1;
                {cas_slot, cas_d} = {n[3:0], v ^ n[7:0]};
                @(negedge CLK) cas_we = 1'b0;
            end
            if (i == 1) begin
                @(negedge CLK) slip = 1'b1;
                @(negedge CLK) slip = 1'b0;
                u_host.ctl1[0] = 8'h0F;
                u_host.ctl1[17] = 8'hFF;
                for (int n = 0; n < 32; n++)
                    u_host.ctl0[n] ^= 8'hC0;
            end
            u_host.frame();
            check("sync word", u_host.stat[18], {sa[5:3], i[0], sa[2:0], 1'b0});
            check("crc word", u_host.stat[21], {sb[5:4], 1'b0, sb[3:1], 1'b0, sb[0]});
            check("phase word", u_host.stat[19], tph);
            check("crc tally", u_host.stat[20], tally);
            check("rx fas", u_host.stat[16], rfa);
            check("rx mfas", u_host.stat[0], rmf);
            check("rx nfas", u_host.stat[17], rnf);
            for (int n = 1; n < 16; n++)
                check("rx cas", u_host.stat[n], v ^ n[7:0]);
            for (int n = 22; n < 32; n++)
                check("empty slot", u_host.stat[n], STATUS_FILL);
            check("tx fas", tfa, 8'h9B);
            check("tx mfas", tmf, i ? 8'h0F : 8'h0B);
            check("tx nfas", tnf, i ? 8'hFF : 8'hDF);
            for (int ch = 0; ch < 31; ch++) begin
                if (ch == 15)
                    continue;
                @(negedge CLK) lch = ch[4:0];
                repeat (2) @(negedge CLK);
                e = u_host.ctl0[ch];
                check("lookup", {6'h00, alternate_digit_inversion, lpb}, {6'h00, ~e[7], e[6]});
                e = ch < 16 ? u_host.ctl1[ch] >> 4 : u_host.ctl1[ch - 15];
                if (ch > 0)
                    check("tx abcd", {4'h0, abcd}, {4'h0, e[3:0]});
            end
            $display("test frame %0d done", i);
        end
        final_report();
    end
endmodule // frame_words_bench
bind frame_words frame_words_monitor u_mon (.CLK(CLK), .RST_N(RST_N), .BIT_STB(BIT_STB),
    .FRAME_PULSE_IN(FRAME_PULSE_IN), .STATUS_STREAM_OUT(STATUS_STREAM_OUT),
    .FRAME_SYNC_LOST(FRAME_SYNC_LOST), .REMOTE_SUBMF2_OK(REMOTE_SUBMF2_OK),
    .TX_TIMESLOT_COUNT(TX_TIMESLOT_COUNT), .CRC_ERROR_TALLY(CRC_ERROR_TALLY),
    .RX_FRAME_ALIGN(RX_FRAME_ALIGN), .RX_MULTIFRAME_ALIGN(RX_MULTIFRAME_ALIGN),
    .RX_NONALIGN_WORD(RX_NONALIGN_WORD));

// ===== tb/frame_words_monitor.sv
// Purpose: Assertions on the serial status stream of frame_words.
// Assumes: The strobe count restarts at every frame pulse.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
module frame_words_monitor (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       RST_N,
    // Watched ports
    input wire logic       BIT_STB,
    input wire logic       FRAME_PULSE_IN,
    input wire logic       STATUS_STREAM_OUT,
    input wire logic       FRAME_SYNC_LOST,
    input wire logic       REMOTE_SUBMF2_OK,
    input wire logic [4:0] TX_TIMESLOT_COUNT,
    input wire logic [7:0] CRC_ERROR_TALLY,
    input wire logic [7:0] RX_FRAME_ALIGN,
    input wire logic [7:0] RX_MULTIFRAME_ALIGN,
    input wire logic [7:0] RX_NONALIGN_WORD
);
    logic [8:0] cnt_reg;
    logic [8:0] cnt_next;
    always_comb begin
        cnt_next = cnt_reg;
        if (FRAME_PULSE_IN)
            cnt_next = 9'h000;
        else if (BIT_STB)
            cnt_next = cnt_reg + 9'h001;
    end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            cnt_reg <= 9'h000;
        else
            cnt_reg <= cnt_next;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Top bit of a slot leaves two clocks after the strobe opening it
    property slot_msb(int n, logic v);
        BIT_STB && cnt_reg == n |-> ##2 STATUS_STREAM_OUT == $past(v, 2);
    endproperty
    a_mfas_msb: assert property (slot_msb(0, RX_MULTIFRAME_ALIGN[7]))
        else $error("status slot 0 top bit wrong");
    a_fas_msb: assert property (slot_msb(128, RX_FRAME_ALIGN[7]))
        else $error("status slot 16 top bit wrong");
    a_nfas_msb: assert property (slot_msb(136, RX_NONALIGN_WORD[7]))
        else $error("status slot 17 top bit wrong");
    a_sync_msb: assert property (slot_msb(144, FRAME_SYNC_LOST))
        else $error("status slot 18 top bit wrong");
    a_phase_msb: assert property (slot_msb(152, TX_TIMESLOT_COUNT[4]))
        else $error("status slot 19 top bit wrong");
    a_tally_msb: assert property (slot_msb(160, CRC_ERROR_TALLY[7]))
        else $error("status slot 20 top bit wrong");
    a_crc_msb: assert property (slot_msb(168, REMOTE_SUBMF2_OK))
        else $error("status slot 21 top bit wrong");
    a_out_timing: assert property ($changed(STATUS_STREAM_OUT) |-> $past(BIT_STB))
        else $error("status stream moved without a strobe");
    cover property (BIT_STB && cnt_reg == 144);
    cover property (FRAME_PULSE_IN);
    cover property ($changed(STATUS_STREAM_OUT));
endmodule // frame_words_monitor
